/* include/adcsq_params.svh */
`ifndef ADCSQ_PARAMS_SVH
`define ADCSQ_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADCSQ_OFF_CTRL1 8'h00
`define ADCSQ_OFF_CTRL2 8'h04
`define ADCSQ_OFF_CTRL3 8'h08
`define ADCSQ_OFF_INSEL 8'h0C
`define ADCSQ_OFF_MASK 8'h10
`define ADCSQ_OFF_STAT 8'h14
`define ADCSQ_OFF_BUF 8'h40
`define ADCSQ_BUF_REGION 8'hC0
`define ADCSQ_BUF_WORD 5:2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCSQ_C1_TRIG 7:5
`define ADCSQ_C1_EDGE 3
`define ADCSQ_C1_AUTO_SAMPLE_ENABLE 2
`define ADCSQ_C1_SAMPLE_CONTROL_BIT 1
`define ADCSQ_C2_REF 15:13
`define ADCSQ_C2_SCAN 10
`define ADCSQ_C2_HALF 7
`define ADCSQ_C2_SAMPLES_PER_INTERRUPT 5:2
`define ADCSQ_C2_DUAL 1
`define ADCSQ_C2_ALTERNATE_MUX_ENABLE 0
`define ADCSQ_C3_AUTO_SAMPLE_TIME 12:8
`define ADCSQ_C3_ADCS 7:0
`define ADCSQ_IS_BNEG 31
`define ADCSQ_IS_BPOS 27:24
`define ADCSQ_IS_ANEG 23
`define ADCSQ_IS_APOS 19:16
`define ADCSQ_MASK_BITS 15:0
`define ADCSQ_ST_FLAG 0
`define ADCSQ_ST_BUSY 1

// ----------------------------------------------------------------
// timing and sequence constants
// ----------------------------------------------------------------
`define ADCSQ_CONV_TAD 4'hC
`define ADCSQ_MIN_SMP_TAD 5'h01
`define ADCSQ_SECOND_HALF 4'h8
`define ADCSQ_FIRST_LOC 4'h0
`define ADCSQ_TADS_PER_CONV 13'h0018

`endif

/* include/adcsq_pkg.sv */
`default_nettype none
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE = 2'h0,
    ADCSQ_SAMPLE = 2'h1,
    ADCSQ_CONVERT = 2'h3
  } adcsq_state_t;

  typedef enum logic [2:0] {
    ADCSQ_TRG_MANUAL = 3'h0,
    ADCSQ_TRG_PIN = 3'h1,
    ADCSQ_TRG_TIMER = 3'h2,
    ADCSQ_TRG_EVENT3 = 3'h3,
    ADCSQ_TRG_AUTO = 3'h7
  } adcsq_trig_t;

  typedef struct packed {
    adcsq_state_t st;
    logic sample_control_bit;
    logic auto_sample_enable;
    logic [2:0] trig;
    logic edge_rise;
    logic [2:0] ref_cfg;
    logic scan_en;
    logic [3:0] samples_per_interrupt;
    logic dual;
    logic alternate_mux_enable;
    logic [4:0] auto_sample_time;
    logic [7:0] adcs;
    logic [3:0] a_pos;
    logic a_neg;
    logic [3:0] b_pos;
    logic b_neg;
    logic [15:0] mask;
    logic flag;
    logic half;
    logic [3:0] cnt;
    logic [3:0] wptr;
    logic alt_b;
    logic [3:0] scan_idx;
    logic [4:0] smp_tad;
    logic [3:0] conv_tad;
    logic [8:0] div;
    logic pin_q;
    logic [3:0] pos;
    logic neg;
    logic [31:0] rdata;
    logic [12:0] conv_cyc;
  } adcsq_top_st_t;

  typedef struct packed {
    logic [15:0][9:0] mem;
  } adcsq_buf_st_t;
endpackage : adcsq_pkg
`default_nettype wire

/* include/adcsq_buf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface adcsq_buf_if;
  logic wr_en;
  logic [3:0] wr_addr;
  logic [9:0] wr_data;
  logic [3:0] rd_addr;
  logic [9:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : adcsq_buf_if
`default_nettype wire

/* logic/adcsq_buf.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// sixteen-word result store
// ----------------------------------------------------------------
module adcsq_buf (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  adcsq_buf_if.mem bus
);
  import adcsq_pkg::*;

  adcsq_buf_st_t s_ff;
  adcsq_buf_st_t nxt_s;

  always_comb begin
    nxt_s = s_ff;
    if (bus.wr_en) begin
      nxt_s.mem[bus.wr_addr] = bus.wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // read is combinational; the bus slave registers it
  assign bus.rd_data = s_ff.mem[bus.rd_addr];
endmodule : adcsq_buf
`default_nettype wire

/* logic/adcsq_scan.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// scan list walker: lowest selected input and next one above
// ----------------------------------------------------------------
module adcsq_scan #(
  parameter int N_IN = 16
) (
  input wire logic [N_IN-1:0] i_mask,
  input wire logic [3:0] i_cur,
  output logic [3:0] o_first,
  output logic [3:0] o_next
);
  always_comb begin
    o_first = 4'h0;
    o_next = 4'h0;
    // reverse loop leaves the lowest match
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (i_mask[i]) begin
        o_first = 4'(i);
      end
    end
    // wrap to the first input when nothing lies above
    o_next = o_first;
    for (int i = N_IN - 1; i >= 0; i--) begin
      if (i_mask[i] && (4'(i) > i_cur)) begin
        o_next = 4'(i);
      end
    end
  end
endmodule : adcsq_scan
`default_nettype wire

/* logic/adcsq_top.sv */
// Notes on behaviour
// R1: trigger 000: clearing sample bit starts conversion
// R2: trigger 010: timer period match starts conversion
// R3: trigger 001: programmed pin edge starts conversion
// R4: trigger 111: sample time field spaces conversions
// R5: event trigger with auto sampling ends sampling; trigger 011 has no source wired here and never ends sampling
// R6: manual sampling waits for software sample bit
// R7: auto sampling restarts after each conversion
// R8: reference config field drives reference select
// R9: scan takes positive input from mask
// R10: scan low to high, restarts per group
// R11: scan negative from mux A bit
// R12: no scan: positive from mux A field
// R13: scan with alternate interleaves mux B input
// R14: samples per group is field plus one, only the low three field bits in dual mode
// R15: after group, write restarts at first location, or at the second half after the first half in dual mode
// R16: software reads results before next group ends
// R17: group length never exceeds sixteen samples
// R18: alternate bit toggles mux A and B
// R19: dual mode fills halves alternately, status shows
// R20: conversion 12 CONVERTER_CLOCK_PERIOD after at least one
// R21: group done sets flag until software clears
// R22: write pointer steps, reloads at group start
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
module adcsq_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_timer_match,
  input wire logic i_ext_pin,
  input wire logic [9:0] i_conv_result,
  output logic o_sampling,
  output logic o_converting,
  output logic [3:0] o_pos_sel,
  output logic o_neg_sel,
  output logic [2:0] o_ref_cfg,
  output logic o_group_flag,
  output logic o_buf_half
);
  import adcsq_pkg::*;

  adcsq_top_st_t s_ff;
  adcsq_top_st_t nxt_s;
  adcsq_buf_if bus ();

  logic tad_en;
  logic pin_edge;
  logic trig_evt;
  logic end_req;
  logic conv_done;
  logic group_end;
  logic use_b;
  logic [3:0] limit;
  logic [3:0] scan_ch;
  logic [3:0] scan_first;
  logic [3:0] scan_next;
  logic [4:0] auto_sample_time_eff;
  logic [12:0] conv_len;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  adcsq_buf u_buf (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .bus(bus)
  );

  adcsq_scan #(.N_IN(16)) u_scan (
    .i_mask(s_ff.mask),
    .i_cur(scan_ch),
    .o_first(scan_first),
    .o_next(scan_next)
  );

  always_comb begin
    tad_en = (s_ff.div == {s_ff.adcs, 1'b1});
    pin_edge = s_ff.edge_rise ? (i_ext_pin & ~s_ff.pin_q) : (~i_ext_pin & s_ff.pin_q); // [R3]
    // event code 011 has no source wired here, so it never fires
    trig_evt = ((s_ff.trig == ADCSQ_TRG_PIN) && pin_edge)
      || ((s_ff.trig == ADCSQ_TRG_TIMER) && i_timer_match); // [R2] [R5]
    auto_sample_time_eff = (s_ff.auto_sample_time < `ADCSQ_MIN_SMP_TAD) ? `ADCSQ_MIN_SMP_TAD : s_ff.auto_sample_time;
    if (s_ff.trig == ADCSQ_TRG_MANUAL) begin
      end_req = !s_ff.sample_control_bit; // [R1]
    end else if (s_ff.trig == ADCSQ_TRG_AUTO) begin
      end_req = (s_ff.smp_tad >= auto_sample_time_eff); // [R4]
    end else begin
      end_req = trig_evt; // [R5]
    end
    // dual halves hold eight words; a 4-bit field caps a group at sixteen
    limit = s_ff.dual ? {1'b0, s_ff.samples_per_interrupt[2:0]} : s_ff.samples_per_interrupt; // [R14] [R17]
    group_end = (s_ff.cnt == limit);
    conv_done = (s_ff.st == ADCSQ_CONVERT) && tad_en && (s_ff.conv_tad == `ADCSQ_CONV_TAD - 4'h1); // [R20]
    use_b = s_ff.alternate_mux_enable && s_ff.alt_b; // [R18]
    scan_ch = (s_ff.cnt == 4'h0) ? scan_first : s_ff.scan_idx; // [R10]
    conv_len = ({5'h00, s_ff.adcs} + 13'h0001) * `ADCSQ_TADS_PER_CONV;
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rdata = 32'h0000_0000;
    nxt_s.pin_q = i_ext_pin;
    nxt_s.div = tad_en ? 9'h000 : s_ff.div + 9'h001;
    bus.wr_en = conv_done;
    bus.wr_addr = s_ff.wptr;
    bus.wr_data = i_conv_result;
    bus.rd_addr = i_addr[`ADCSQ_BUF_WORD];

    if (i_wr) begin
      if (i_addr == `ADCSQ_OFF_CTRL1) begin
        nxt_s.trig = i_wdata[`ADCSQ_C1_TRIG];
        nxt_s.edge_rise = i_wdata[`ADCSQ_C1_EDGE];
        nxt_s.auto_sample_enable = i_wdata[`ADCSQ_C1_AUTO_SAMPLE_ENABLE];
        nxt_s.sample_control_bit = i_wdata[`ADCSQ_C1_SAMPLE_CONTROL_BIT]; // [R6]
      end else if (i_addr == `ADCSQ_OFF_CTRL2) begin
        nxt_s.ref_cfg = i_wdata[`ADCSQ_C2_REF];
        nxt_s.scan_en = i_wdata[`ADCSQ_C2_SCAN];
        nxt_s.samples_per_interrupt = i_wdata[`ADCSQ_C2_SAMPLES_PER_INTERRUPT];
        nxt_s.dual = i_wdata[`ADCSQ_C2_DUAL];
        nxt_s.alternate_mux_enable = i_wdata[`ADCSQ_C2_ALTERNATE_MUX_ENABLE];
      end else if (i_addr == `ADCSQ_OFF_CTRL3) begin
        nxt_s.auto_sample_time = i_wdata[`ADCSQ_C3_AUTO_SAMPLE_TIME];
        nxt_s.adcs = i_wdata[`ADCSQ_C3_ADCS];
      end else if (i_addr == `ADCSQ_OFF_INSEL) begin
        nxt_s.b_neg = i_wdata[`ADCSQ_IS_BNEG];
        nxt_s.b_pos = i_wdata[`ADCSQ_IS_BPOS];
        nxt_s.a_neg = i_wdata[`ADCSQ_IS_ANEG];
        nxt_s.a_pos = i_wdata[`ADCSQ_IS_APOS];
      end else if (i_addr == `ADCSQ_OFF_MASK) begin
        nxt_s.mask = i_wdata[`ADCSQ_MASK_BITS];
      end else if (i_addr == `ADCSQ_OFF_STAT) begin
        if (i_wdata[`ADCSQ_ST_FLAG]) begin
          nxt_s.flag = 1'b0;
        end
      end
    end

    if (i_rd) begin
      if (i_addr == `ADCSQ_OFF_CTRL1) begin
        nxt_s.rdata[`ADCSQ_C1_TRIG] = s_ff.trig;
        nxt_s.rdata[`ADCSQ_C1_EDGE] = s_ff.edge_rise;
        nxt_s.rdata[`ADCSQ_C1_AUTO_SAMPLE_ENABLE] = s_ff.auto_sample_enable;
        nxt_s.rdata[`ADCSQ_C1_SAMPLE_CONTROL_BIT] = s_ff.sample_control_bit;
      end else if (i_addr == `ADCSQ_OFF_CTRL2) begin
        nxt_s.rdata[`ADCSQ_C2_REF] = s_ff.ref_cfg;
        nxt_s.rdata[`ADCSQ_C2_SCAN] = s_ff.scan_en;
        nxt_s.rdata[`ADCSQ_C2_HALF] = s_ff.half; // [R19]
        nxt_s.rdata[`ADCSQ_C2_SAMPLES_PER_INTERRUPT] = s_ff.samples_per_interrupt;
        nxt_s.rdata[`ADCSQ_C2_DUAL] = s_ff.dual;
        nxt_s.rdata[`ADCSQ_C2_ALTERNATE_MUX_ENABLE] = s_ff.alternate_mux_enable;
      end else if (i_addr == `ADCSQ_OFF_CTRL3) begin
        nxt_s.rdata[`ADCSQ_C3_AUTO_SAMPLE_TIME] = s_ff.auto_sample_time;
        nxt_s.rdata[`ADCSQ_C3_ADCS] = s_ff.adcs;
      end else if (i_addr == `ADCSQ_OFF_INSEL) begin
        nxt_s.rdata[`ADCSQ_IS_BNEG] = s_ff.b_neg;
        nxt_s.rdata[`ADCSQ_IS_BPOS] = s_ff.b_pos;
        nxt_s.rdata[`ADCSQ_IS_ANEG] = s_ff.a_neg;
        nxt_s.rdata[`ADCSQ_IS_APOS] = s_ff.a_pos;
      end else if (i_addr == `ADCSQ_OFF_MASK) begin
        nxt_s.rdata[`ADCSQ_MASK_BITS] = s_ff.mask;
      end else if (i_addr == `ADCSQ_OFF_STAT) begin
        nxt_s.rdata[`ADCSQ_ST_FLAG] = s_ff.flag;
        nxt_s.rdata[`ADCSQ_ST_BUSY] = (s_ff.st != ADCSQ_IDLE);
      end else if ((i_addr & `ADCSQ_BUF_REGION) == `ADCSQ_OFF_BUF) begin
        nxt_s.rdata[9:0] = bus.rd_data;
      end
    end

    // input select holds still while a conversion runs
    if (s_ff.st != ADCSQ_CONVERT) begin
      if (use_b) begin
        nxt_s.pos = s_ff.b_pos; // [R13] [R18]
        nxt_s.neg = s_ff.b_neg;
      end else begin
        nxt_s.pos = s_ff.scan_en ? scan_ch : s_ff.a_pos; // [R9] [R12]
        nxt_s.neg = s_ff.a_neg; // [R11]
      end
    end

    // ----------------------------------------------------------------
    // sample and convert sequencer
    // ----------------------------------------------------------------
    nxt_s.conv_cyc = (s_ff.st == ADCSQ_CONVERT) ? s_ff.conv_cyc + 13'h0001 : 13'h0000;
    case (s_ff.st)
      ADCSQ_IDLE: begin
        nxt_s.smp_tad = 5'h00;
        if (s_ff.sample_control_bit) begin
          nxt_s.st = ADCSQ_SAMPLE; // [R6]
        end
      end
      ADCSQ_SAMPLE: begin
        if (tad_en && (s_ff.smp_tad != 5'h1F)) begin
          nxt_s.smp_tad = s_ff.smp_tad + 5'h01;
        end
        // a pin or timer trigger that lands before one CONVERTER_CLOCK_PERIOD of sampling is dropped
        if (end_req && (s_ff.smp_tad >= `ADCSQ_MIN_SMP_TAD)) begin
          nxt_s.st = ADCSQ_CONVERT; // [R1] [R2] [R3] [R4] [R5] [R20]
          nxt_s.sample_control_bit = 1'b0;
          nxt_s.conv_tad = 4'h0;
          nxt_s.div = 9'h000;
        end else if (!s_ff.sample_control_bit && (s_ff.trig != ADCSQ_TRG_MANUAL)) begin
          nxt_s.st = ADCSQ_IDLE;
        end
      end
      ADCSQ_CONVERT: begin
        if (tad_en) begin
          nxt_s.conv_tad = s_ff.conv_tad + 4'h1;
        end
        if (conv_done) begin
          nxt_s.smp_tad = 5'h00;
          nxt_s.sample_control_bit = s_ff.auto_sample_enable; // [R6] [R7]
          nxt_s.st = s_ff.auto_sample_enable ? ADCSQ_SAMPLE : ADCSQ_IDLE; // [R7]
          if (group_end) begin
            nxt_s.flag = 1'b1; // [R21]
            nxt_s.cnt = 4'h0;
            nxt_s.alt_b = 1'b0;
            nxt_s.half = s_ff.dual & ~s_ff.half; // [R19]
            nxt_s.wptr = (s_ff.dual && !s_ff.half) ? `ADCSQ_SECOND_HALF : `ADCSQ_FIRST_LOC; // [R15] [R22]
          end else begin
            nxt_s.cnt = s_ff.cnt + 4'h1; // [R14]
            nxt_s.wptr = s_ff.wptr + 4'h1; // [R22]
            nxt_s.alt_b = s_ff.alternate_mux_enable & ~s_ff.alt_b; // [R18]
            if (!use_b) begin
              nxt_s.scan_idx = scan_next; // [R10] [R13]
            end
          end
        end
      end
      default: begin
        nxt_s.st = ADCSQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign o_rdata = s_ff.rdata;
  assign o_sampling = (s_ff.st == ADCSQ_SAMPLE);
  assign o_converting = (s_ff.st == ADCSQ_CONVERT);
  assign o_pos_sel = s_ff.pos;
  assign o_neg_sel = s_ff.neg;
  assign o_ref_cfg = s_ff.ref_cfg; // [R8]
  assign o_group_flag = s_ff.flag;
  assign o_buf_half = s_ff.half;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_b);

  chk_manual_end: assert property ((s_ff.st == ADCSQ_SAMPLE) && (s_ff.trig == ADCSQ_TRG_MANUAL) && !s_ff.sample_control_bit // [R1]
    && (s_ff.smp_tad >= `ADCSQ_MIN_SMP_TAD) |=> (s_ff.st == ADCSQ_CONVERT)) else $error("manual end missed");
  chk_timer_start: assert property ((s_ff.st == ADCSQ_SAMPLE) && (s_ff.trig == ADCSQ_TRG_TIMER) && s_ff.sample_control_bit // [R2]
    && i_timer_match && (s_ff.smp_tad >= `ADCSQ_MIN_SMP_TAD) |=> o_converting) else $error("timer trigger missed");
  chk_event_only: assert property ((s_ff.st == ADCSQ_SAMPLE) && (s_ff.trig == ADCSQ_TRG_TIMER) // [R5]
    && !i_timer_match |=> !o_converting) else $error("conversion without trigger");
  chk_pin_edge: assert property ((s_ff.st == ADCSQ_SAMPLE) && (s_ff.trig == ADCSQ_TRG_PIN) && s_ff.sample_control_bit // [R3]
    && (s_ff.edge_rise ? $rose(i_ext_pin) : $fell(i_ext_pin)) && (s_ff.smp_tad >= `ADCSQ_MIN_SMP_TAD)
    |=> o_converting) else $error("pin edge missed");
  chk_auto_time: assert property ((s_ff.st == ADCSQ_SAMPLE) && (s_ff.trig == ADCSQ_TRG_AUTO) // [R4]
    && (s_ff.smp_tad < auto_sample_time_eff) |=> !o_converting) else $error("auto sample too short");
  chk_manual_hold: assert property ((s_ff.st == ADCSQ_IDLE) && !s_ff.sample_control_bit && !i_wr // [R6]
    |=> !o_sampling) else $error("sampling without sample bit");
  chk_auto_restart: assert property (conv_done && s_ff.auto_sample_enable |=> o_sampling && s_ff.sample_control_bit) // [R7]
    else $error("auto sampling did not restart");
  chk_conv_length: assert property (conv_done |-> (s_ff.conv_cyc == conv_len - 13'h0001)) // [R20]
    else $error("conversion length wrong");
  chk_group_flag: assert property (conv_done && group_end |=> o_group_flag && (s_ff.cnt == 4'h0)) // [R21]
    else $error("group flag not set");
  chk_wptr_step: assert property (conv_done && !group_end |=> (s_ff.wptr == $past(s_ff.wptr) + 4'h1)) // [R22]
    else $error("write pointer did not step");
  chk_dual_half: assert property (conv_done && group_end && s_ff.dual // [R19]
    |=> (s_ff.wptr == (s_ff.half ? `ADCSQ_SECOND_HALF : `ADCSQ_FIRST_LOC)) && (s_ff.half != $past(s_ff.half)))
    else $error("dual buffer half wrong");

  cov_group_done: cover property (conv_done && group_end);
  cov_dual_second: cover property (conv_done && s_ff.dual && s_ff.half);
  cov_scan_alt: cover property (conv_done && s_ff.scan_en && s_ff.alternate_mux_enable && use_b);
  cov_auto_conv: cover property ((s_ff.trig == ADCSQ_TRG_AUTO) && conv_done);
endmodule : adcsq_top
`default_nettype wire

/* tb/adcsq_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// analog front end and trigger timer stand-in
// ----------------------------------------------------------------
module adcsq_front_model #(
  parameter int TMR_PERIOD = 100
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_tmr_en,
  input wire logic [3:0] i_pos_sel,
  input wire logic i_neg_sel,
  output logic o_timer_match,
  output logic [9:0] o_conv_result
);
  int cnt_ff;

  // result encodes the selected inputs, so a stored word shows which input was converted
  assign o_conv_result = {i_neg_sel, 1'b1, i_pos_sel, 4'h5};

  // one-cycle period match pulse; the count restarts whenever the timer is stopped
  always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_ff <= 0;
      o_timer_match <= 1'b0;
    end else begin
      o_timer_match <= i_tmr_en && (cnt_ff == TMR_PERIOD - 1);
      cnt_ff <= (!i_tmr_en || cnt_ff == TMR_PERIOD - 1) ? 0 : cnt_ff + 1;
    end
  end
endmodule : adcsq_front_model
`default_nettype wire

/* tb/adc_sequence_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module adc_sequence_control_tb_top;
  localparam int TMR_PERIOD = 100;
  localparam int SMP = 0;
  localparam int CNV = 1;
  localparam int FLG = 2;
  logic i_ref_clk, i_rst_b, i_wr, i_rd, i_ext_pin, tmr_en, tmr_match;
  logic o_sampling, o_converting, o_neg_sel, o_group_flag, o_buf_half;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, rv;
  logic [9:0] conv_res;
  logic [3:0] o_pos_sel;
  logic [2:0] o_ref_cfg;
  logic [2:0] st;
  logic [3:0] sc [3] = '{4'h2, 4'h5, 4'h7};
  logic [3:0] alt [4] = '{4'h1, 4'h9, 4'h3, 4'h9};
  int n_fail, n_checks, n;
  time t0;

  assign st = {o_group_flag, o_converting, o_sampling};

  adcsq_top i_dut (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_timer_match(tmr_match),
    .i_ext_pin(i_ext_pin), .i_conv_result(conv_res), .o_sampling(o_sampling),
    .o_converting(o_converting), .o_pos_sel(o_pos_sel), .o_neg_sel(o_neg_sel),
    .o_ref_cfg(o_ref_cfg), .o_group_flag(o_group_flag), .o_buf_half(o_buf_half)
  );

  adcsq_front_model #(.TMR_PERIOD(TMR_PERIOD)) i_front (
    .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_tmr_en(tmr_en), .i_pos_sel(o_pos_sel),
    .i_neg_sel(o_neg_sel), .o_timer_match(tmr_match), .o_conv_result(conv_res)
  );

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ----------------------------------------------------------------
  // bus and wait helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] res(input logic ng, input logic [3:0] p);
    return {ng, 1'b1, p, 4'h5};
  endfunction : res

  // an idle edge after each write keeps the strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
    @(posedge i_ref_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    rv = o_rdata;
    @(posedge i_ref_clk);
  endtask : rd

  task automatic wait_on(input int k, input logic v, input int lim);
    for (int j = 0; j < lim; j++) begin
      @(posedge i_ref_clk);
      if (st[k] === v) return;
    end
    `CHK("wait", v, st[k])
    give_verdict();
  endtask : wait_on

  task automatic give_verdict();
    if (n_fail == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0000_0000;
    i_ext_pin = 1'b0;
    tmr_en = 1'b0;
    n_fail = 0;
    n_checks = 0;
    repeat (3) @(posedge i_ref_clk);
    i_rst_b <= 1'b1;
    @(posedge i_ref_clk);
    `CHK("rst_outs", 12'h000, {st, o_pos_sel, o_neg_sel, o_ref_cfg, o_buf_half})
    rd(`ADCSQ_OFF_CTRL2);
    `CHK("ctrl2_rst", 32'h0000_0000, rv)
    rd(8'h30);
    `CHK("unmapped", 32'h0000_0000, rv)
    // manual sampling, conversion started by software
    wr(`ADCSQ_OFF_CTRL2, 32'h0000_A000);
    wr(`ADCSQ_OFF_INSEL, 32'h0085_0000);
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0002);
    wait_on(SMP, 1'b1, 10);
    `CHK("ref_cfg", 3'h5, o_ref_cfg)
    repeat (20) @(posedge i_ref_clk);
    `CHK("pos_sel", 5'h15, {o_neg_sel, o_pos_sel})
    `CHK("no_conv", 1'b0, o_converting)
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0000);
    wait_on(CNV, 1'b1, 10);
    n = 0;
    while (o_converting === 1'b1 && n < 100) begin
      n++;
      @(posedge i_ref_clk);
    end
    `CHK("conv_len", 24, n)
    repeat (10) @(posedge i_ref_clk);
    `CHK("manual_idle", 2'b00, {o_sampling, o_converting})
    `CHK("flag", 1'b1, o_group_flag)
    rd(`ADCSQ_OFF_BUF);
    `CHK("word0", res(1'b1, 4'h5), rv[9:0])
    wr(`ADCSQ_OFF_STAT, 32'h0000_0001);
    rd(`ADCSQ_OFF_STAT);
    `CHK("flag_clr", 3'b000, {o_group_flag, rv[1:0]})
    // timer trigger with auto sampling over a five-input scan, three per group
    wr(`ADCSQ_OFF_CTRL2, 32'h0000_0408);
    wr(`ADCSQ_OFF_MASK, 32'h0000_0AA4);
    wr(`ADCSQ_OFF_INSEL, 32'h0000_0000);
    tmr_en <= 1'b1;
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0046);
    wait_on(CNV, 1'b1, 300);
    t0 = $time;
    wait_on(CNV, 1'b0, 40);
    `CHK("resample", 1'b1, o_sampling)
    wait_on(CNV, 1'b1, 300);
    `CHK("trig_rate", TMR_PERIOD, int'(($time - t0) / 10))
    wait_on(FLG, 1'b1, 600);
    for (int i = 0; i < 3; i++) begin
      rd(`ADCSQ_OFF_BUF + 8'(i * 4));
      `CHK("scan", res(1'b0, sc[i]), rv[9:0])
    end
    wr(`ADCSQ_OFF_STAT, 32'h0000_0001);
    wait_on(FLG, 1'b1, 600);
    // stop in timer mode: clearing the sample bit under trigger 000 would start one more conversion
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0040);
    tmr_en <= 1'b0;
    wait_on(CNV, 1'b0, 40);
    // a pointer that failed to reload would have reached word 3 in the second group
    rd(`ADCSQ_OFF_BUF + 8'h0C);
    `CHK("restart", 10'h000, rv[9:0])
    // auto-convert, scan interleaved with the fixed second input
    wr(`ADCSQ_OFF_STAT, 32'h0000_0001);
    wr(`ADCSQ_OFF_CTRL3, 32'h0000_0200);
    rd(`ADCSQ_OFF_CTRL3);
    `CHK("ctrl3", 32'h0000_0200, rv)
    wr(`ADCSQ_OFF_CTRL2, 32'h0000_040D);
    wr(`ADCSQ_OFF_MASK, 32'h0000_000A);
    wr(`ADCSQ_OFF_INSEL, 32'h0900_0000);
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_00E6);
    wait_on(CNV, 1'b1, 100);
    wait_on(CNV, 1'b0, 40);
    n = 0;
    while (o_sampling === 1'b1 && n < 100) begin
      n++;
      @(posedge i_ref_clk);
    end
    // divider phase at sampling start may add one cycle to the two-period window
    `CHK("smp_time", 1'b1, (n >= 4 && n <= 6))
    wait_on(FLG, 1'b1, 400);
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0040);
    wait_on(CNV, 1'b0, 40);
    for (int i = 0; i < 4; i++) begin
      rd(`ADCSQ_OFF_BUF + 8'(i * 4));
      `CHK("alt", res(1'b0, alt[i]), rv[9:0])
    end
    // pin trigger on rising edge, dual buffer halves
    wr(`ADCSQ_OFF_STAT, 32'h0000_0001);
    wr(`ADCSQ_OFF_CTRL2, 32'h0000_0002);
    wr(`ADCSQ_OFF_INSEL, 32'h0003_0000);
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_002E);
    repeat (10) @(posedge i_ref_clk);
    i_ext_pin <= 1'b1;
    wait_on(CNV, 1'b1, 6);
    wait_on(FLG, 1'b1, 60);
    rd(`ADCSQ_OFF_CTRL2);
    `CHK("half_one", 2'b11, {o_buf_half, rv[7]})
    wr(`ADCSQ_OFF_STAT, 32'h0000_0001);
    wr(`ADCSQ_OFF_INSEL, 32'h0004_0000);
    i_ext_pin <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    `CHK("fall_ignored", 1'b0, o_converting)
    i_ext_pin <= 1'b1;
    wait_on(FLG, 1'b1, 60);
    `CHK("half_zero", 1'b0, o_buf_half)
    wr(`ADCSQ_OFF_CTRL1, 32'h0000_0040);
    wait_on(CNV, 1'b0, 40);
    rd(`ADCSQ_OFF_BUF);
    `CHK("half_a", res(1'b0, 4'h3), rv[9:0])
    rd(`ADCSQ_OFF_BUF + 8'h20);
    `CHK("half_b", res(1'b0, 4'h4), rv[9:0])
    give_verdict();
  end
endmodule : adc_sequence_control_tb_top
`default_nettype wire
